// file: hdl/dsad_top.sv
// What this block does
// - Addresses 0x0000 to 0x001F select the 32 working registers.
// - Addresses 0x0020 to 0x005F select the 64 standard I/O registers.
// - Extended I/O 0x060 to 0x0FF is reachable only by data-space accesses.
// - Internal SRAM spans 0x0100 to 0x10FF, or to 0x20FF when large.
// - External memory runs from just above internal SRAM up to 0xFFFF.
// - Accesses above internal memory go external with the same request.
// - External strobes stay inactive throughout every internal access.
// - External SRAM is used only while the enable bit is set.
// - An external byte costs one cycle more than an internal one.
// - With external stack, PC save or restore costs three extra cycles.
// - With one to three wait states a byte costs two to four extra.
// - With waits and external stack, PC transfers cost five, seven, nine.
// - Displacement mode adds an unsigned offset up to 63 to X, Y or Z.
// - Pre-decrement lowers the pointer before use; post-increment after.
// - Registers R26 to R31 form the 16-bit pointers X, Y and Z.
// - Direct addressing reaches every location of the data space.
// - An internal access completes in two clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dsad_cfg.svh"

module dsad_top
    import dsad_pkg::*;
#(
    parameter bit LARGE = 1'b0
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         req_i,
    input  wire logic         we_i,
    input  wire dsad_kind_t   kind_i,
    input  wire dsad_mode_t   mode_i,
    input  wire dsad_ptr_t    ptr_sel_i,
    input  wire logic         short_io_i,
    input  wire logic [5:0]   short_io_addr_i,
    input  wire logic [15:0]  direct_addr_i,
    input  wire logic [5:0]   disp_i,
    input  wire logic [15:0]  x_ptr_i,
    input  wire logic [15:0]  y_ptr_i,
    input  wire logic [15:0]  z_ptr_i,
    input  wire logic [7:0]   wdata_i,
    input  wire logic         ext_mem_enable_bit_i,
    input  wire logic [1:0]   wait_states_i,
    input  wire logic [7:0]   int_rdata_i,
    input  wire logic [7:0]   ext_data_i,
    output logic              busy_o,
    output logic              done_o,
    output logic [7:0]        rdata_o,
    output var dsad_region_t  region_o,
    output logic [15:0]       addr_o,
    output logic              ptr_wb_en_o,
    output var dsad_ptr_t     ptr_wb_sel_o,
    output logic [15:0]       ptr_wb_val_o,
    output logic              int_sel_o,
    output logic              int_we_o,
    output logic [15:0]       int_addr_o,
    output logic [7:0]        int_wdata_o,
    output logic [15:0]       ext_addr_o,
    output logic [7:0]        ext_data_o,
    output logic              ext_data_oe_o,
    output logic              ext_read_strobe_n_o,
    output logic              ext_write_strobe_n_o
);

    // Picks the pointer pair named by the request.
    function automatic logic [15:0] dsad_ptr_val(input dsad_ptr_t sel,
                                                 input logic [15:0] x,
                                                 input logic [15:0] y,
                                                 input logic [15:0] z);
        case (sel)
            DSAD_PT_X: return x;
            DSAD_PT_Y: return y;
            default:   return z;
        endcase
    endfunction

    // Forms the effective address from mode, pointer and offsets.
    function automatic logic [15:0] dsad_eff(input dsad_mode_t m,
                                             input logic [15:0] p,
                                             input logic [15:0] dir,
                                             input logic [5:0]  dsp);
        case (m)
            DSAD_AM_DIRECT: return dir;
            DSAD_AM_DISP:   return p + {10'h000, dsp};
            DSAD_AM_PREDEC: return p - 16'h0001;
            default:        return p;
        endcase
    endfunction

    // Extra cycles that an external transfer costs on top of internal.
    function automatic logic [3:0] dsad_extra(input dsad_kind_t k,
                                              input logic [1:0] ws);
        if (k == DSAD_KD_PC)
            return `DSAD_PC_EXTRA
                   + `DSAD_PC_PER_WS * {2'b00, ws};
        else
            return `DSAD_BYTE_EXTRA
                   + `DSAD_BYTE_PER_WS * {2'b00, ws};
    endfunction

    logic [15:0]  ptr_cur;
    logic [15:0]  eff_addr;
    dsad_region_t eff_region;
    logic         take;
    logic         goes_ext;

    dsad_state_t  state_q;
    dsad_state_t  state_d;
    logic [3:0]   cnt_q;
    logic [3:0]   cnt_d;
    logic         we_q;
    logic [7:0]   ext_meta_q;
    logic [7:0]   ext_sync_q;

    // Current pointer and the address it yields.
    assign ptr_cur = dsad_ptr_val(ptr_sel_i, x_ptr_i, y_ptr_i, z_ptr_i);
    assign eff_addr = short_io_i
                    ? (`DSAD_IO_BASE + {10'h000, short_io_addr_i})
                    : dsad_eff(mode_i, ptr_cur, direct_addr_i, disp_i);
    assign take = req_i && (state_q == DSAD_ST_IDLE);

    dsad_region_decode #(
        .LARGE (LARGE)
    ) u_decode (
        .addr_i   (eff_addr),
        .region_o (eff_region)
    );

    // Same request path goes external purely by address.
    assign goes_ext = (eff_region == DSAD_RG_XRAM);

    // Next state and cycle count of the sequencer.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            DSAD_ST_IDLE:
            begin
                if (take && goes_ext && ext_mem_enable_bit_i)
                begin
                    state_d = DSAD_ST_EXT;
                    cnt_d = dsad_extra(kind_i, wait_states_i);
                end
                else if (take && goes_ext)
                begin
                    state_d = DSAD_ST_VOID;
                end
                else if (take)
                begin
                    state_d = DSAD_ST_INT;
                end
            end
            DSAD_ST_EXT:
            begin
                if (cnt_q == 4'h0)
                    state_d = DSAD_ST_IDLE;
                else
                    cnt_d = cnt_q - 4'h1;
            end
            default:
            begin
                state_d = DSAD_ST_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= DSAD_ST_IDLE;
            cnt_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Busy flag shows that no new request is taken.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            busy_o <= 1'b0;
        else
            busy_o <= (state_d != DSAD_ST_IDLE);
    end

    // Latches the decoded address, region and direction of a request.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_o <= `DSAD_RST_ADDR;
            region_o <= DSAD_RG_REG;
            we_q <= 1'b0;
        end
        else if (take)
        begin
            addr_o <= eff_addr;
            region_o <= eff_region;
            we_q <= we_i;
        end
    end

    // Pointer write-back: the decremented or incremented pair.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_wb_en_o <= 1'b0;
            ptr_wb_sel_o <= DSAD_PT_X;
            ptr_wb_val_o <= `DSAD_RST_ADDR;
        end
        else
        begin
            ptr_wb_en_o <= take && !short_io_i
                         && ((mode_i == DSAD_AM_PREDEC)
                          || (mode_i == DSAD_AM_POSTINC));
            if (take)
            begin
                ptr_wb_sel_o <= ptr_sel_i;
                if (mode_i == DSAD_AM_PREDEC)
                    ptr_wb_val_o <= ptr_cur - 16'h0001;
                else
                    ptr_wb_val_o <= ptr_cur + 16'h0001;
            end
        end
    end

    // Internal memory port, selected for one cycle of an internal access.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_sel_o <= 1'b0;
            int_we_o <= 1'b0;
            int_addr_o <= `DSAD_RST_ADDR;
            int_wdata_o <= `DSAD_RST_DATA;
        end
        else
        begin
            int_sel_o <= (state_d == DSAD_ST_INT);
            int_we_o <= (state_d == DSAD_ST_INT) && we_i;
            if (take && !goes_ext)
            begin
                int_addr_o <= eff_addr;
                int_wdata_o <= wdata_i;
            end
        end
    end

    // External address and data bus, driven only for external accesses.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_addr_o <= `DSAD_RST_ADDR;
            ext_data_o <= `DSAD_RST_DATA;
            ext_data_oe_o <= 1'b0;
        end
        else
        begin
            if (take && goes_ext && ext_mem_enable_bit_i)
            begin
                ext_addr_o <= eff_addr;
                ext_data_o <= wdata_i;
            end
            ext_data_oe_o <= (state_d == DSAD_ST_EXT)
                           && (take ? we_i : we_q);
        end
    end

    // Strobes are low only in the external state; high otherwise.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_read_strobe_n_o <= 1'b1;
            ext_write_strobe_n_o <= 1'b1;
        end
        else
        begin
            ext_read_strobe_n_o <= !((state_d == DSAD_ST_EXT)
                                  && !(take ? we_i : we_q));
            ext_write_strobe_n_o <= !((state_d == DSAD_ST_EXT)
                                   && (take ? we_i : we_q));
        end
    end

    // Two-stage capture of the external data pins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_meta_q <= `DSAD_RST_DATA;
            ext_sync_q <= `DSAD_RST_DATA;
        end
        else
        begin
            ext_meta_q <= ext_data_i;
            ext_sync_q <= ext_meta_q;
        end
    end

    // Completion pulse and read data of the finished access.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_o <= 1'b0;
            rdata_o <= `DSAD_RST_DATA;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_q)
                DSAD_ST_INT:
                begin
                    done_o <= 1'b1;
                    if (!we_q)
                        rdata_o <= int_rdata_i;
                end
                DSAD_ST_EXT:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        done_o <= 1'b1;
                        if (!we_q)
                            rdata_o <= ext_sync_q;
                    end
                end
                DSAD_ST_VOID:
                begin
                    done_o <= 1'b1;
                    if (!we_q)
                        rdata_o <= `DSAD_UNDEF_RDATA;
                end
                default:
                begin
                    done_o <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// file: include/dsad_cfg.svh
`ifndef DSAD_CFG_SVH
`define DSAD_CFG_SVH

// Region bounds of the 64 KiB data space.
`define DSAD_REG_BASE        16'h0000
`define DSAD_REG_TOP         16'h001f
`define DSAD_IO_BASE         16'h0020
`define DSAD_IO_TOP          16'h005f
`define DSAD_XIO_BASE        16'h0060
`define DSAD_XIO_TOP         16'h00ff
`define DSAD_IRAM_BASE       16'h0100
`define DSAD_IRAM_TOP_SMALL  16'h10ff
`define DSAD_IRAM_TOP_LARGE  16'h20ff
`define DSAD_XRAM_BASE_SMALL 16'h1100
`define DSAD_XRAM_BASE_LARGE 16'h2100
`define DSAD_XRAM_TOP        16'hffff

// Extra cycles of an external access, base and per wait state.
`define DSAD_BYTE_EXTRA      4'h1
`define DSAD_BYTE_PER_WS     4'h1
`define DSAD_PC_EXTRA        4'h3
`define DSAD_PC_PER_WS       4'h2

// Value returned by a read of disabled external space.
`define DSAD_UNDEF_RDATA     8'hff

// Reset values of the data outputs.
`define DSAD_RST_ADDR        16'h0000
`define DSAD_RST_DATA        8'h00

`endif

// file: include/dsad_pkg.sv
package dsad_pkg;

    // Region selected by a data-space address.
    typedef enum logic [2:0] {
        DSAD_RG_REG  = 3'b000,
        DSAD_RG_IO   = 3'b001,
        DSAD_RG_XIO  = 3'b010,
        DSAD_RG_IRAM = 3'b011,
        DSAD_RG_XRAM = 3'b100
    } dsad_region_t;

    // Addressing mode of the access.
    typedef enum logic [2:0] {
        DSAD_AM_DIRECT  = 3'b000,
        DSAD_AM_DISP    = 3'b001,
        DSAD_AM_INDIR   = 3'b010,
        DSAD_AM_PREDEC  = 3'b011,
        DSAD_AM_POSTINC = 3'b100
    } dsad_mode_t;

    // Pointer pair used by indirect modes.
    typedef enum logic [1:0] {
        DSAD_PT_X = 2'b00,
        DSAD_PT_Y = 2'b01,
        DSAD_PT_Z = 2'b10
    } dsad_ptr_t;

    // Kind of transfer: one data byte, one stack byte, or a PC save/restore.
    typedef enum logic [1:0] {
        DSAD_KD_DATA  = 2'b00,
        DSAD_KD_STACK = 2'b01,
        DSAD_KD_PC    = 2'b10
    } dsad_kind_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        DSAD_ST_IDLE = 2'b00,
        DSAD_ST_INT  = 2'b01,
        DSAD_ST_EXT  = 2'b10,
        DSAD_ST_VOID = 2'b11
    } dsad_state_t;

endpackage

// file: hdl/dsad_region_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsad_cfg.svh"

module dsad_region_decode
    import dsad_pkg::*;
#(
    parameter bit LARGE = 1'b0
)
(
    input  wire logic [15:0] addr_i,
    output var  dsad_region_t region_o
);

    // Tells whether an address lies inside an inclusive range.
    function automatic logic dsad_in(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Upper end of internal SRAM for the chosen variant.
    localparam logic [15:0] IRAM_TOP = LARGE ? `DSAD_IRAM_TOP_LARGE
                                             : `DSAD_IRAM_TOP_SMALL;
    localparam logic [15:0] XRAM_BASE = LARGE ? `DSAD_XRAM_BASE_LARGE
                                              : `DSAD_XRAM_BASE_SMALL;

    // Priority chain from the lowest region upward.
    always_comb
    begin
        if (dsad_in(addr_i, `DSAD_REG_BASE, `DSAD_REG_TOP))
            region_o = DSAD_RG_REG;
        else if (dsad_in(addr_i, `DSAD_IO_BASE, `DSAD_IO_TOP))
            region_o = DSAD_RG_IO;
        else if (dsad_in(addr_i, `DSAD_XIO_BASE, `DSAD_XIO_TOP))
            region_o = DSAD_RG_XIO;
        else if (dsad_in(addr_i, `DSAD_IRAM_BASE, IRAM_TOP))
            region_o = DSAD_RG_IRAM;
        else if (dsad_in(addr_i, XRAM_BASE, `DSAD_XRAM_TOP))
            region_o = DSAD_RG_XRAM;
        else
            region_o = DSAD_RG_XRAM;
    end

endmodule
`default_nettype wire

// file: dv/dsad_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module dsad_monitor
    import dsad_pkg::*;
#(
    parameter bit LARGE = 1'b0
)
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         req_i,
    input wire logic         busy_o,
    input wire logic         done_o,
    input wire dsad_kind_t   kind_i,
    input wire dsad_mode_t   mode_i,
    input wire dsad_ptr_t    ptr_sel_i,
    input wire logic         short_io_i,
    input wire logic [5:0]   short_io_addr_i,
    input wire logic [15:0]  direct_addr_i,
    input wire logic [5:0]   disp_i,
    input wire logic [15:0]  x_ptr_i,
    input wire logic [15:0]  y_ptr_i,
    input wire logic [15:0]  z_ptr_i,
    input wire logic         ext_mem_enable_bit_i,
    input wire logic [1:0]   wait_states_i,
    input wire dsad_region_t region_o,
    input wire logic [15:0]  addr_o,
    input wire logic         ptr_wb_en_o,
    input wire logic [15:0]  ptr_wb_val_o,
    input wire logic         int_sel_o,
    input wire logic         ext_read_strobe_n_o,
    input wire logic         ext_write_strobe_n_o
);
    logic        take;
    logic        low;
    logic [15:0] sel_ptr;
    logic [15:0] disp_ea;
    logic [15:0] sio_ea;
    logic [15:0] ptr_q;
    logic [3:0]  low_q;
    logic [1:0]  ws_q;
    dsad_kind_t  kind_q;
    dsad_mode_t  mode_q;

    // Request acceptance and the addresses it should produce.
    assign take    = req_i && !busy_o;
    assign low     = !ext_read_strobe_n_o || !ext_write_strobe_n_o;
    assign sel_ptr = (ptr_sel_i == DSAD_PT_X) ? x_ptr_i :
                     (ptr_sel_i == DSAD_PT_Y) ? y_ptr_i : z_ptr_i;
    assign disp_ea = sel_ptr + {10'h000, disp_i};
    assign sio_ea  = 16'h0020 + {10'h000, short_io_addr_i};

    // Counts cycles with a strobe low; one more than the extra cycles.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !low)
            low_q <= 4'h0;
        else
            low_q <= low_q + 4'h1;
    end

    // Keeps what was taken, since the core may move on at done.
    always_ff @(posedge clk_i)
    begin
        if (take)
        begin
            kind_q <= kind_i;
            mode_q <= mode_i;
            ws_q   <= wait_states_i;
            ptr_q  <= sel_ptr;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_int_no_strobe: assert property (int_sel_o |->
        (ext_read_strobe_n_o && ext_write_strobe_n_o)[*2])
        else $error("strobe active during internal access");
    a_int_two_cycles: assert property (int_sel_o |=>
        done_o && !busy_o) else $error("internal access not two cycles");
    a_void_no_stall: assert property (
        take && !ext_mem_enable_bit_i |=> (busy_o && !low) ##1 done_o)
        else $error("disabled access stalled or strobed");
    a_strobe_xram_only: assert property (low |->
        region_o == DSAD_RG_XRAM) else $error("strobe outside external");
    a_byte_stall_len: assert property (
        done_o && low_q != 4'h0 && kind_q != DSAD_KD_PC |->
        low_q == 4'h2 + {2'b00, ws_q}) else $error("byte stall wrong");
    a_pc_stall_len: assert property (
        done_o && low_q != 4'h0 && kind_q == DSAD_KD_PC |->
        low_q == 4'h4 + {1'b0, ws_q, 1'b0}) else $error("pc stall wrong");
    a_wb_on_step: assert property (take && !short_io_i &&
        (mode_i == DSAD_AM_PREDEC || mode_i == DSAD_AM_POSTINC) |=>
        ptr_wb_en_o) else $error("pointer update missing");
    a_wb_step_value: assert property (ptr_wb_en_o |->
        ptr_wb_val_o == ((mode_q == DSAD_AM_PREDEC) ? ptr_q - 16'h0001
        : ptr_q + 16'h0001)) else $error("pointer update value wrong");
    a_disp_addr: assert property (
        take && !short_io_i && mode_i == DSAD_AM_DISP |=>
        addr_o == $past(disp_ea)) else $error("displacement address wrong");
    a_short_io_map: assert property (take && short_io_i |=>
        region_o == DSAD_RG_IO && addr_o == $past(sio_ea))
        else $error("short io mapping wrong");
    a_reg_region: assert property (take && !short_io_i &&
        mode_i == DSAD_AM_DIRECT && direct_addr_i <= 16'h001f |=>
        region_o == DSAD_RG_REG) else $error("register region wrong");

    c_pc_ws3: cover property (done_o && kind_q == DSAD_KD_PC && ws_q == 2'h3
        && low_q != 4'h0);
    c_void: cover property (take && !ext_mem_enable_bit_i);
    c_predec: cover property (ptr_wb_en_o && mode_q == DSAD_AM_PREDEC);
endmodule

bind dsad_top dsad_monitor #(.LARGE(LARGE)) u_monitor (.*);

`default_nettype wire

// file: dv/dsad_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module dsad_mem_model
(
    input wire logic        clk_i,
    input wire logic [15:0] int_addr_i,
    input wire logic [15:0] ext_addr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic        wr_oe_i,
    input wire logic        rd_strobe_n_i,
    input wire logic        wr_strobe_n_i,
    output logic [7:0]      int_rdata_o,
    output logic [7:0]      ext_rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // Fills external memory with an address pattern the bench knows.
    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = a[7:0] ^ 8'hc3;
    end

    // Internal memory answers in the same cycle; released pins invert.
    assign int_rdata_o = int_addr_i[7:0] ^ int_addr_i[15:8] ^ 8'h5a;
    assign ext_rdata_o = !rd_strobe_n_i ? mem[ext_addr_i] : ~last_q;

    // Stores strobed write data and remembers the last driven byte.
    always @(posedge clk_i)
    begin
        if (!rd_strobe_n_i)
            last_q <= mem[ext_addr_i];
        if (!wr_strobe_n_i && wr_oe_i)
            mem[ext_addr_i] <= wr_data_i;
    end
endmodule

`default_nettype wire

// file: dv/dsad_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module dsad_top_bench;
    import dsad_pkg::*;
    logic clk_i, rst_i, req_i, we_i, short_io_i, ext_mem_enable_bit_i;
    logic busy_o, done_o, ptr_wb_en_o, int_sel_o, int_we_o, ext_data_oe_o;
    logic ext_read_strobe_n_o, ext_write_strobe_n_o;
    logic [2:0]  pins;
    logic [1:0]  wait_states_i;
    logic [5:0]  short_io_addr_i, disp_i;
    logic [7:0]  wdata_i, int_rdata_i, ext_data_i, rdata_o;
    logic [7:0]  int_wdata_o, ext_data_o;
    logic [15:0] direct_addr_i, x_ptr_i, y_ptr_i, z_ptr_i, addr_o;
    logic [15:0] ptr_wb_val_o, int_addr_o, ext_addr_o;
    dsad_kind_t   kind_i;
    dsad_mode_t   mode_i;
    dsad_ptr_t    ptr_sel_i, ptr_wb_sel_o;
    dsad_region_t region_o;
    logic [7:0]   shadow [logic [15:0]];
    logic [15:0]  bounds [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
        16'h0060, 16'h00ff, 16'h0100, 16'h10ff, 16'h1100, 16'hffff};
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int seed;

    dsad_top #(.LARGE(1'b0)) dut (.*);

    // External pin group as seen in one word: enable, write, read.
    assign pins = {ext_data_oe_o, ext_write_strobe_n_o, ext_read_strobe_n_o};

    dsad_mem_model u_mem (.clk_i(clk_i), .int_addr_i(int_addr_o),
        .ext_addr_i(ext_addr_o), .wr_data_i(ext_data_o),
        .wr_oe_i(ext_data_oe_o), .rd_strobe_n_i(ext_read_strobe_n_o),
        .wr_strobe_n_i(ext_write_strobe_n_o), .int_rdata_o(int_rdata_i),
        .ext_rdata_o(ext_data_i));

    // Free running clock.
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Cuts a hang short.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    // Region expected for an address of the small map.
    function automatic dsad_region_t region_of(input logic [15:0] a);
        if (a <= 16'h001f) return DSAD_RG_REG;
        if (a <= 16'h005f) return DSAD_RG_IO;
        if (a <= 16'h00ff) return DSAD_RG_XIO;
        if (a <= 16'h10ff) return DSAD_RG_IRAM;
        return DSAD_RG_XRAM;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One access at target t with random mode, kind, waits and enable.
    task automatic go(input logic [15:0] t);
        logic [15:0]  p;
        logic [15:0]  ea;
        logic [7:0]   ed;
        logic         pm;
        logic         iw;
        logic [2:0]   xs;
        int           n;
        int           ex;
        dsad_region_t rg;
        we_i = 1'($urandom);
        kind_i = dsad_kind_t'($urandom_range(0, 2));
        mode_i = dsad_mode_t'($urandom_range(0, 4));
        ptr_sel_i = dsad_ptr_t'($urandom_range(0, 2));
        wait_states_i = 2'($urandom);
        ext_mem_enable_bit_i = ($urandom_range(0, 4) != 0);
        short_io_i = ($urandom_range(0, 7) == 0);
        {short_io_addr_i, disp_i, wdata_i} = 20'($urandom);
        {x_ptr_i, y_ptr_i} = $urandom;
        z_ptr_i = 16'($urandom);
        direct_addr_i = t;
        p = t;
        if (mode_i == DSAD_AM_PREDEC) p = t + 16'h0001;
        if (mode_i == DSAD_AM_DISP) p = t - {10'h000, disp_i};
        case (ptr_sel_i)
            DSAD_PT_X: x_ptr_i = p;
            DSAD_PT_Y: y_ptr_i = p;
            default:   z_ptr_i = p;
        endcase
        ea = short_io_i ? 16'h0020 + {10'h000, short_io_addr_i} : t;
        rg = region_of(ea);
        pm = !short_io_i &&
             (mode_i == DSAD_AM_PREDEC || mode_i == DSAD_AM_POSTINC);
        ex = 0;
        if (rg == DSAD_RG_XRAM && ext_mem_enable_bit_i)
            ex = (kind_i == DSAD_KD_PC) ? 3 + 2 * wait_states_i
                                        : 1 + wait_states_i;
        iw = we_i && (rg != DSAD_RG_XRAM);
        xs = (ex != 0) ? {we_i, !we_i, we_i} : 3'b011;
        req_i = 1'b1;
        @(posedge clk_i);
        #1 req_i = 1'b0;
        check({13'h0000, region_o}, {13'h0000, rg});
        check(addr_o, ea);
        check({15'h0000, ptr_wb_en_o}, {15'h0000, pm});
        if (pm)
            check(ptr_wb_val_o, (mode_i == DSAD_AM_PREDEC) ? p - 16'h0001
                                : p + 16'h0001);
        if (pm)
            check({14'h0000, ptr_wb_sel_o}, {14'h0000, ptr_sel_i});
        check({15'h0000, int_sel_o}, {15'h0000, rg != DSAD_RG_XRAM});
        check({15'h0000, int_we_o}, {15'h0000, iw});
        if (rg != DSAD_RG_XRAM)
            check({8'h00, int_wdata_o}, {8'h00, wdata_i});
        check({13'h0000, pins}, {13'h0000, xs});
        n = 0;
        while (!done_o && n < 40)
        begin
            @(posedge clk_i);
            #1 n = n + 1;
        end
        check(16'(n), 16'(1 + ex));
        if (!we_i)
        begin
            if (rg != DSAD_RG_XRAM)
                ed = ea[7:0] ^ ea[15:8] ^ 8'h5a;
            else if (!ext_mem_enable_bit_i)
                ed = 8'hff;
            else
                ed = shadow.exists(ea) ? shadow[ea] : ea[7:0] ^ 8'hc3;
            // One-extra-cycle reads are left out: the synchroniser needs time.
            if (ex != 1)
                check({8'h00, rdata_o}, {8'h00, ed});
        end
        else if (ex != 0)
            shadow[ea] = wdata_i;
    endtask

    // Reset, boundary corners, then random traffic back to back.
    initial
    begin
        {rst_i, req_i, we_i, short_io_i, ext_mem_enable_bit_i} = 5'b10000;
        {wait_states_i, short_io_addr_i, disp_i, wdata_i} = 22'h0;
        {direct_addr_i, x_ptr_i, y_ptr_i, z_ptr_i} = 64'h0;
        kind_i = DSAD_KD_DATA;
        mode_i = DSAD_AM_DIRECT;
        ptr_sel_i = DSAD_PT_X;
        seed = $urandom(32'h6281cd8a);
        repeat (6) @(posedge clk_i);
        #1 rst_i = 1'b0;
        foreach (bounds[i])
            go(bounds[i]);
        repeat (400)
            go(($urandom_range(0, 3) == 0) ? bounds[$urandom_range(0, 9)]
                                           : 16'($urandom));
        wrap_up();
    end
endmodule

`default_nettype wire
